// ### common/vxd_pkg.sv
// Purpose: Shared constants for the stage-2 control, domain access and
//          hypervisor trap register bank.
// Assumes: Registers are reached by coprocessor register-transfers.
// Notes:   Field positions and selector codes are named here only once.
package vxd_pkg;
	// ********************************************************************
	// Selector codes of the coprocessor transfer.
	// ********************************************************************
	localparam logic [2:0] S2C_OPC1 = 3'h4;
	localparam logic [3:0] S2C_CRN = 4'h2;
	localparam logic [3:0] S2C_CRM = 4'h1;
	localparam logic [2:0] S2C_OPC2 = 3'h2;
	localparam logic [2:0] DOM_OPC1 = 3'h0;
	localparam logic [3:0] DOM_CRN = 4'h3;
	localparam logic [3:0] DOM_CRM = 4'h0;
	localparam logic [2:0] DOM_OPC2 = 3'h0;
	localparam logic [2:0] TRP_OPC1 = 3'h4;
	localparam logic [3:0] TRP_CRN = 4'h1;
	localparam logic [3:0] TRP_CRM = 4'h1;
	localparam logic [2:0] TRP_OPC2 = 3'h3;
	// ********************************************************************
	// Field layout of the stage-2 control register.
	// ********************************************************************
	localparam int S2C_SH_LO = 12;
	localparam int S2C_ORGN_LO = 10;
	localparam int S2C_IRGN_LO = 8;
	localparam int S2C_SL_LO = 6;
	localparam int S2C_SIGN_BIT = 4;
	localparam int S2C_SZ_MSB = 3;
	localparam logic [31:0] S2C_WMASK = 32'h00003FDF;
	localparam logic [31:0] S2C_FIXED1 = 32'h80000000;
	localparam logic [31:0] S2C_RESET = 32'h80000000;
	// Trap mask: implemented bits 0-3, 5-13 and 15; bit 16 reads zero.
	localparam logic [31:0] TRP_WMASK = 32'h0000BFEF;
	localparam logic [31:0] TRP_RESET = 32'h00000000;
	localparam logic [31:0] DOM_RESET = 32'h00000000;
	localparam logic [1:0] SIZE_OFS_BASE = 2'h0;
	localparam logic [5:0] ADDR_BITS_BASE = 6'h20;
	// ********************************************************************
	// Domain permission codes, shareability codes and levels.
	// ********************************************************************
	localparam logic [1:0] DOM_NO_ACCESS = 2'h0;
	localparam logic [1:0] DOM_CLIENT = 2'h1;
	localparam logic [1:0] DOM_RESERVED = 2'h2;
	localparam logic [1:0] DOM_MANAGER = 2'h3;
	localparam logic [1:0] SH_RESERVED = 2'h1;
	localparam logic [1:0] SH_NON = 2'h0;
	localparam logic [1:0] LVL_USER = 2'h0;
	localparam logic [1:0] LVL_KERNEL = 2'h1;
	localparam logic [1:0] LVL_HYP = 2'h2;
	localparam logic [1:0] LVL_MONITOR = 2'h3;
	localparam logic [3:0] NO_TRAP_CRN = 4'h4;
	localparam logic [3:0] NO_TRAP_CRN2 = 4'hE;
endpackage : vxd_pkg

// ### design/vxd_domain_check.sv
// Purpose: Domain permission check for one access.
// Assumes: Permission word is the copy chosen for the current world.
// Notes:   Output is registered; result follows the request by one cycle.
`timescale 1ns/1ps
module vxd_domain_check (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Request.
	input wire logic chk_valid,
	input wire logic [3:0] chk_domain,
	input wire logic [31:0] perm_word,
	input wire logic long_descriptor_enable,
	// Result.
	output logic chk_done,
	output logic chk_fault,
	output logic chk_use_perm
);
	logic [1:0] field;

	// Pick the two-bit field of the addressed domain.
	assign field = perm_word[{chk_domain, 1'b0} +: 2];

	// Long format ignores the domains entirely; reserved code acts
	// like no access so a misprogrammed field can never widen rights.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			chk_done <= 1'b0;
			chk_fault <= 1'b0;
			chk_use_perm <= 1'b0;
		end else begin
			chk_done <= chk_valid;
			if (long_descriptor_enable) begin
				chk_fault <= 1'b0;
				chk_use_perm <= 1'b1;
			end else begin
				chk_fault <= chk_valid &&
					(field == vxd_pkg::DOM_NO_ACCESS ||
					field == vxd_pkg::DOM_RESERVED);
				chk_use_perm <= field == vxd_pkg::DOM_CLIENT;
			end
		end
	end
endmodule : vxd_domain_check

// ### design/vxd_regs.sv
// Purpose: Stage-2 translation control, domain access and hypervisor
//          trap registers with their decode and effect logic.
// Assumes: One register transfer per cycle from the core pipeline.
// Notes:   Read data and denial follow a transfer by one cycle.
`timescale 1ns/1ps
module vxd_regs (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Register transfer from the core.
	input wire logic xfer_valid,
	input wire logic xfer_write,
	input wire logic [2:0] xfer_opc1,
	input wire logic [3:0] xfer_crn,
	input wire logic [3:0] xfer_crm,
	input wire logic [2:0] xfer_opc2,
	input wire logic [31:0] xfer_wdata,
	// Execution context.
	input wire logic [1:0] cur_level,
	input wire logic nonsecure_state_bit,
	input wire logic monitor_is_32bit,
	input wire logic long_descriptor_enable,
	// Transfer answer.
	output logic xfer_done,
	output logic xfer_denied,
	output logic xfer_trapped,
	output logic [31:0] xfer_rdata,
	// Domain check request and result.
	input wire logic dom_chk_valid,
	input wire logic [3:0] dom_chk_domain,
	output logic dom_chk_done,
	output logic dom_fault,
	output logic dom_use_perm,
	// Stage-2 walk attributes.
	output logic [1:0] walk_shareability,
	output logic [1:0] walk_outer_cache,
	output logic [1:0] walk_inner_cache,
	output logic walk_start_first,
	output logic [3:0] region_size_offset,
	output logic [5:0] stage2_addr_bits
);
	logic [31:0] stage2_xlat_ctrl;
	logic [31:0] domain_access_ctrl_s;
	logic [31:0] domain_access_ctrl_ns;
	logic [31:0] hyp_trap_ctrl;
	logic hit_s2c;
	logic hit_dom;
	logic hit_trp;
	logic nonsec_now;
	logic hyp_ok;
	logic dom_ok;
	logic use_ns_copy;
	logic [31:0] dom_sel;
	logic [31:0] next_rdata;
	logic next_denied;
	logic [3:0] eff_size;

	// Masked register write keeps fixed bits at their reset values.
	function automatic logic [31:0] merge_w(input logic [31:0] old,
		input logic [31:0] wd, input logic [31:0] msk);
		merge_w = (old & ~msk) | (wd & msk);
	endfunction : merge_w

	// ********************************************************************
	// Decode of the transfer selector.
	// ********************************************************************
	assign hit_s2c = xfer_opc1 == vxd_pkg::S2C_OPC1 &&
		xfer_crn == vxd_pkg::S2C_CRN && xfer_crm == vxd_pkg::S2C_CRM &&
		xfer_opc2 == vxd_pkg::S2C_OPC2;
	assign hit_dom = xfer_opc1 == vxd_pkg::DOM_OPC1 &&
		xfer_crn == vxd_pkg::DOM_CRN && xfer_crm == vxd_pkg::DOM_CRM &&
		xfer_opc2 == vxd_pkg::DOM_OPC2;
	assign hit_trp = xfer_opc1 == vxd_pkg::TRP_OPC1 &&
		xfer_crn == vxd_pkg::TRP_CRN && xfer_crm == vxd_pkg::TRP_CRM &&
		xfer_opc2 == vxd_pkg::TRP_OPC2;

	// Hypervisor is non-secure; monitor counts as non-secure when its
	// state bit is one, everything else follows that bit too.
	assign nonsec_now = cur_level == vxd_pkg::LVL_HYP ||
		nonsecure_state_bit;
	assign hyp_ok = cur_level == vxd_pkg::LVL_HYP ||
		(cur_level == vxd_pkg::LVL_MONITOR &&
		nonsecure_state_bit);
	assign dom_ok = cur_level != vxd_pkg::LVL_USER;

	// A 64-bit monitor has no banked copy, so the non-secure one serves.
	assign use_ns_copy = nonsec_now || !monitor_is_32bit;
	assign dom_sel = use_ns_copy ? domain_access_ctrl_ns :
		domain_access_ctrl_s;

	// ********************************************************************
	// Register storage.
	// ********************************************************************
	// Stage-2 control: only a permitted write changes it.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stage2_xlat_ctrl <= vxd_pkg::S2C_RESET;
		end else if (xfer_valid && xfer_write && hit_s2c && hyp_ok) begin
			stage2_xlat_ctrl <= merge_w(stage2_xlat_ctrl, xfer_wdata,
				vxd_pkg::S2C_WMASK) | vxd_pkg::S2C_FIXED1;
		end
	end

	// Secure domain copy; written from secure kernel or monitor, only while the monitor is 32-bit.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			domain_access_ctrl_s <= vxd_pkg::DOM_RESET;
		end else if (xfer_valid && xfer_write && hit_dom && dom_ok &&
			!use_ns_copy) begin
			domain_access_ctrl_s <= xfer_wdata;
		end
	end

	// Non-secure domain copy.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			domain_access_ctrl_ns <= vxd_pkg::DOM_RESET;
		end else if (xfer_valid && xfer_write && hit_dom && dom_ok &&
			use_ns_copy) begin
			domain_access_ctrl_ns <= xfer_wdata;
		end
	end

	// Trap register: unimplemented bits, bit 16 among them, stay zero.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hyp_trap_ctrl <= vxd_pkg::TRP_RESET;
		end else if (xfer_valid && xfer_write && hit_trp && hyp_ok) begin
			hyp_trap_ctrl <= merge_w(hyp_trap_ctrl, xfer_wdata,
				vxd_pkg::TRP_WMASK);
		end
	end

	// ********************************************************************
	// Read mux and denial.
	// ********************************************************************
	// Unknown selectors read zero and are not denied here; another
	// block of the core owns them.
	always_comb begin
		next_rdata = 32'h00000000;
		next_denied = 1'b0;
		if (hit_s2c) begin
			next_denied = !hyp_ok;
			if (hyp_ok)
				next_rdata = stage2_xlat_ctrl;
		end else if (hit_dom) begin
			next_denied = !dom_ok;
			if (dom_ok)
				next_rdata = dom_sel;
		end else if (hit_trp) begin
			next_denied = !hyp_ok;
			if (hyp_ok)
				next_rdata = hyp_trap_ctrl;
		end
	end

	// Answer register; read data only valid for reads.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			xfer_done <= 1'b0;
			xfer_denied <= 1'b0;
			xfer_rdata <= 32'h00000000;
		end else begin
			xfer_done <= xfer_valid;
			xfer_denied <= xfer_valid && next_denied;
			xfer_rdata <= (xfer_valid && !xfer_write) ? next_rdata :
				32'h00000000;
		end
	end

	// ********************************************************************
	// Stage-2 walk attributes.
	// ********************************************************************
	// On a sign mismatch any legal value is allowed; zero is picked.
	assign eff_size = (stage2_xlat_ctrl[vxd_pkg::S2C_SIGN_BIT] ==
		stage2_xlat_ctrl[vxd_pkg::S2C_SZ_MSB]) ?
		stage2_xlat_ctrl[vxd_pkg::S2C_SZ_MSB:0] : 4'h0;

	// Attributes drive the walker for non-secure guest walks.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			walk_shareability <= vxd_pkg::SH_NON;
			walk_outer_cache <= 2'h0;
			walk_inner_cache <= 2'h0;
			walk_start_first <= 1'b0;
			region_size_offset <= 4'h0;
			stage2_addr_bits <= vxd_pkg::ADDR_BITS_BASE;
		end else begin
			// Reserved code 01 is passed as non-shareable.
			walk_shareability <= (stage2_xlat_ctrl[vxd_pkg::S2C_SH_LO +: 2]
				== vxd_pkg::SH_RESERVED) ? vxd_pkg::SH_NON :
				stage2_xlat_ctrl[vxd_pkg::S2C_SH_LO +: 2];
			walk_outer_cache <=
				stage2_xlat_ctrl[vxd_pkg::S2C_ORGN_LO +: 2];
			walk_inner_cache <=
				stage2_xlat_ctrl[vxd_pkg::S2C_IRGN_LO +: 2];
			walk_start_first <= stage2_xlat_ctrl[vxd_pkg::S2C_SL_LO];
			region_size_offset <= eff_size;
			stage2_addr_bits <= vxd_pkg::ADDR_BITS_BASE -
				{2'h0, eff_size};
		end
	end

	// ********************************************************************
	// Sub-blocks.
	// ********************************************************************
	// Domain check uses the copy of the current world.
	vxd_domain_check u_dom (
		.clk(clk),
		.rst_b(rst_b),
		.chk_valid(dom_chk_valid),
		.chk_domain(dom_chk_domain),
		.perm_word(dom_sel),
		.long_descriptor_enable(long_descriptor_enable),
		.chk_done(dom_chk_done),
		.chk_fault(dom_fault),
		.chk_use_perm(dom_use_perm)
	);

	// Trap decision for every transfer the core presents.
	vxd_trap_decode u_trap (
		.clk(clk),
		.rst_b(rst_b),
		.acc_valid(xfer_valid),
		.acc_crn(xfer_crn),
		.acc_level(cur_level),
		.acc_nonsecure(nonsecure_state_bit),
		.trap_word(hyp_trap_ctrl),
		.trap_hit(xfer_trapped)
	);
endmodule : vxd_regs

// ### design/vxd_trap_decode.sv
// Purpose: Decide whether a coprocessor access is redirected to the
//          hypervisor.
// Assumes: Trap register value comes from the register bank.
// Notes:   Result registered; one cycle after the request.
`timescale 1ns/1ps
module vxd_trap_decode (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Access under test.
	input wire logic acc_valid,
	input wire logic [3:0] acc_crn,
	input wire logic [1:0] acc_level,
	input wire logic acc_nonsecure,
	input wire logic [31:0] trap_word,
	// Result.
	output logic trap_hit
);
	// Only non-secure kernel or user accesses are ever redirected.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			trap_hit <= 1'b0;
		end else begin
			trap_hit <= acc_valid && acc_nonsecure &&
				(acc_level == vxd_pkg::LVL_USER ||
				acc_level == vxd_pkg::LVL_KERNEL) &&
				trap_word[acc_crn];
		end
	end
endmodule : vxd_trap_decode

// ### dv/vxd_regs_sva.sv
// Purpose: Port-level assertions for the register bank.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound to every instance of the bank.
`timescale 1ns/1ps
module vxd_regs_sva (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Requests and context.
	input wire logic xfer_valid,
	input wire logic xfer_write,
	input wire logic [2:0] xfer_opc1,
	input wire logic [3:0] xfer_crn,
	input wire logic [3:0] xfer_crm,
	input wire logic [2:0] xfer_opc2,
	input wire logic [1:0] cur_level,
	input wire logic nonsecure_state_bit,
	input wire logic long_descriptor_enable,
	input wire logic dom_chk_valid,
	// Answers.
	input wire logic xfer_done,
	input wire logic xfer_denied,
	input wire logic xfer_trapped,
	input wire logic [31:0] xfer_rdata,
	input wire logic dom_chk_done,
	input wire logic dom_fault,
	input wire logic dom_use_perm,
	input wire logic [1:0] walk_shareability
);
	logic [13:0] sel;
	logic hyp;
	// Selector and level decode shared by the properties.
	assign sel = {xfer_opc1, xfer_crn, xfer_crm, xfer_opc2};
	assign hyp = cur_level == vxd_pkg::LVL_HYP;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_s2c_rd;
		xfer_valid && !xfer_write && hyp && sel == {vxd_pkg::S2C_OPC1,
			vxd_pkg::S2C_CRN, vxd_pkg::S2C_CRM, vxd_pkg::S2C_OPC2};
	endsequence
	sequence s_trp_rd;
		xfer_valid && !xfer_write && hyp && sel == {vxd_pkg::TRP_OPC1,
			vxd_pkg::TRP_CRN, vxd_pkg::TRP_CRM, vxd_pkg::TRP_OPC2};
	endsequence
	a_done_one_cycle: assert property (xfer_valid |=> xfer_done)
		else $error("transfer answer missing");
	a_done_no_request: assert property (!xfer_valid |=> !xfer_done)
		else $error("answer without transfer");
	a_s2c_kernel_denied: assert property (xfer_valid && !nonsecure_state_bit
		&& cur_level == vxd_pkg::LVL_KERNEL && sel == {vxd_pkg::S2C_OPC1,
		vxd_pkg::S2C_CRN, vxd_pkg::S2C_CRM, vxd_pkg::S2C_OPC2}
		|=> xfer_denied)
		else $error("kernel reached stage-2 control");
	a_dom_user_denied: assert property (xfer_valid && !nonsecure_state_bit
		&& cur_level == vxd_pkg::LVL_USER && sel == {vxd_pkg::DOM_OPC1,
		vxd_pkg::DOM_CRN, vxd_pkg::DOM_CRM, vxd_pkg::DOM_OPC2}
		|=> xfer_denied)
		else $error("user reached domain register");
	a_denied_reads_zero: assert property (xfer_denied |-> xfer_rdata == 32'h0)
		else $error("denied access returned data");
	a_s2c_fixed_bits: assert property (s_s2c_rd |=> xfer_rdata[31]
		&& xfer_rdata[30:14] == 17'h0 && !xfer_rdata[5])
		else $error("stage-2 reserved bits wrong");
	a_trap_fixed_bits: assert property (s_trp_rd |=> xfer_rdata[31:16] == 16'h0
		&& !xfer_rdata[14] && !xfer_rdata[4])
		else $error("trap reserved bits wrong");
	a_no_trap_secure: assert property (xfer_valid && (!nonsecure_state_bit
		|| cur_level >= vxd_pkg::LVL_HYP) |=> !xfer_trapped)
		else $error("trap outside non-secure low levels");
	a_share_legal: assert property (walk_shareability != vxd_pkg::SH_RESERVED)
		else $error("reserved shareability driven");
	a_long_desc_bypass: assert property (dom_chk_valid && long_descriptor_enable
		|=> dom_chk_done && !dom_fault && dom_use_perm)
		else $error("domain check active in long format");
endmodule : vxd_regs_sva
bind vxd_regs vxd_regs_sva vxd_regs_sva_inst (.clk, .rst_b, .xfer_valid,
	.xfer_write, .xfer_opc1, .xfer_crn, .xfer_crm, .xfer_opc2, .cur_level,
	.nonsecure_state_bit, .long_descriptor_enable, .dom_chk_valid, .xfer_done,
	.xfer_denied, .xfer_trapped, .xfer_rdata, .dom_chk_done, .dom_fault,
	.dom_use_perm, .walk_shareability);

// ### dv/vxd_regs_tb.sv
// Purpose: Self-checking bench for the register bank.
// Assumes: Answers come one cycle after each request.
// Notes:   Expected answers are queued by the driver, popped by a monitor.
`timescale 1ns/1ps
module vxd_regs_tb;
	localparam logic [13:0] S2C = {vxd_pkg::S2C_OPC1, vxd_pkg::S2C_CRN,
		vxd_pkg::S2C_CRM, vxd_pkg::S2C_OPC2};
	localparam logic [13:0] DOM = {vxd_pkg::DOM_OPC1, vxd_pkg::DOM_CRN,
		vxd_pkg::DOM_CRM, vxd_pkg::DOM_OPC2};
	localparam logic [13:0] TRP = {vxd_pkg::TRP_OPC1, vxd_pkg::TRP_CRN,
		vxd_pkg::TRP_CRM, vxd_pkg::TRP_OPC2};
	// Domain words use only the legal codes 00, 01 and 11.
	localparam logic [31:0] DSEC = 32'hD4D4D4D4;
	localparam logic [31:0] DNSEC = 32'h1D1D1D1D;
	localparam logic [2:0] HYP = 3'h5, MON_NS = 3'h7, MON_S = 3'h6;
	localparam logic [2:0] KER_S = 3'h2, KER_NS = 3'h3, USR_S = 3'h0;
	logic clk, rst_b, xfer_valid, xfer_write, nonsecure_state_bit;
	logic monitor_is_32bit, long_descriptor_enable, dom_chk_valid;
	logic xfer_done, xfer_denied, xfer_trapped, dom_chk_done, dom_fault;
	logic dom_use_perm, walk_start_first;
	logic [2:0] xfer_opc1, xfer_opc2;
	logic [3:0] xfer_crn, xfer_crm, dom_chk_domain, region_size_offset;
	logic [31:0] xfer_wdata, xfer_rdata, seed, v, s2c, trp;
	logic [1:0] cur_level, walk_shareability, walk_outer_cache, walk_inner_cache;
	logic [5:0] stage2_addr_bits;
	logic [3:0] off;
	logic [33:0] xq[$];
	logic [1:0] dq[$];
	int fails, num_checks;
	vxd_regs vxd_regs_inst (.clk, .rst_b, .xfer_valid, .xfer_write, .xfer_opc1,
		.xfer_crn, .xfer_crm, .xfer_opc2, .xfer_wdata, .cur_level,
		.nonsecure_state_bit, .monitor_is_32bit, .long_descriptor_enable,
		.xfer_done, .xfer_denied, .xfer_trapped, .xfer_rdata, .dom_chk_valid,
		.dom_chk_domain, .dom_chk_done, .dom_fault, .dom_use_perm,
		.walk_shareability, .walk_outer_cache, .walk_inner_cache,
		.walk_start_first, .region_size_offset, .stage2_addr_bits);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task chk(input string nm, input logic [33:0] exp, input logic [33:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task summarize();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize
	// One transfer; the expected {denied, trapped, rdata} is queued.
	task xf(input logic w, input logic [13:0] s, input logic [31:0] wd,
		input logic [2:0] ctx, input logic [33:0] exp);
		@(posedge clk);
		xfer_valid <= 1'b1;
		xfer_write <= w;
		{xfer_opc1, xfer_crn, xfer_crm, xfer_opc2} <= s;
		xfer_wdata <= wd;
		{cur_level, nonsecure_state_bit} <= ctx;
		xq.push_back(exp);
	endtask : xf
	// One domain check; copy chosen by world, bypassed in long format.
	task dc(input logic [3:0] d, input logic [2:0] ctx, input logic le,
		input logic m32);
		logic [1:0] c;
		c = (ctx[0] || !m32) ? DNSEC[{d, 1'b0} +: 2] : DSEC[{d, 1'b0} +: 2];
		@(posedge clk);
		dom_chk_valid <= 1'b1;
		dom_chk_domain <= d;
		{cur_level, nonsecure_state_bit} <= ctx;
		long_descriptor_enable <= le;
		monitor_is_32bit <= m32;
		dq.push_back(le ? 2'h1 : {c == 2'h0 || c == 2'h2, c == 2'h1});
	endtask : dc
	task idle();
		@(posedge clk);
		xfer_valid <= 1'b0;
		dom_chk_valid <= 1'b0;
	endtask : idle
	// ****************************************************************
	// Clock, watchdog and answer monitor.
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// The whole run needs well under a thousand cycles.
	initial begin
		#20000;
		fails++;
		summarize();
	end
	// Answers are looked at mid-cycle, where they have settled.
	always @(negedge clk) begin
		if (xfer_done === 1'b1) chk("xfer", xq.pop_front(), {xfer_denied, xfer_trapped, xfer_rdata});
		if (dom_chk_done === 1'b1) chk("dom", {32'h0, dq.pop_front()}, {32'h0, dom_fault, dom_use_perm});
	end
	// ****************************************************************
	// Main sequence.
	// ****************************************************************
	initial begin
		seed = 32'h00009F2C;
		{rst_b, xfer_valid, xfer_write, dom_chk_valid} = 4'h0;
		{xfer_opc1, xfer_crn, xfer_crm, xfer_opc2} = 14'h0;
		{cur_level, nonsecure_state_bit, long_descriptor_enable} = 4'h0;
		{xfer_wdata, dom_chk_domain, monitor_is_32bit} = 37'h1;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		chk("addr", 34'h20, {28'h0, stage2_addr_bits});
		xf(1'b0, S2C, 32'h0, HYP, {2'h0, vxd_pkg::S2C_RESET});
		xf(1'b0, TRP, 32'h0, MON_NS, 34'h0);
		for (int i = 0; i < 4; i++) begin
			v = rnd();
			v[13:6] = {i[1:0], i[1:0], ~i[1:0], 1'b0, i[0]};
			// Even passes obey the sign rule; odd ones may break it.
			if (!i[0]) v[4] = v[3];
			off = (v[4] == v[3]) ? v[3:0] : 4'h0;
			xf(1'b1, S2C, v, i[0] ? MON_NS : HYP, 34'h0);
			s2c = (v & vxd_pkg::S2C_WMASK) | vxd_pkg::S2C_FIXED1;
			xf(1'b0, S2C, 32'h0, HYP, {2'h0, s2c});
			idle();
			repeat (2) @(negedge clk);
			chk("walk", {17'h0, (v[13:12] == 2'h1) ? 2'h0 : v[13:12],
				v[11:8], v[6], off, 6'h20 - {2'h0, off}},
				{17'h0, walk_shareability, walk_outer_cache,
				walk_inner_cache, walk_start_first, region_size_offset,
				stage2_addr_bits});
		end
		for (int k = 0; k < 4; k++) begin
			v = {USR_S, KER_S, KER_NS, MON_S, 20'h0} >> (29 - 3 * k);
			xf(1'b1, S2C, 32'hFFFFFFFF, v[2:0], {2'h2, 32'h0});
			xf(1'b1, TRP, 32'hFFFFFFFF, v[2:0], {2'h2, 32'h0});
		end
		xf(1'b1, DOM, 32'hFFFFFFFF, USR_S, {2'h2, 32'h0});
		xf(1'b0, S2C, 32'h0, HYP, {2'h0, s2c});
		xf(1'b1, TRP, 32'hFFFFFFFF, HYP, 34'h0);
		xf(1'b0, TRP, 32'h0, HYP, {2'h0, vxd_pkg::TRP_WMASK});
		trp = rnd() & vxd_pkg::TRP_WMASK;
		xf(1'b1, TRP, trp, HYP, 34'h0);
		for (int c = 0; c < 16; c++) begin
			v = {3'h7, c[3:0], 4'hF, 3'h7};
			xf(1'b0, v[13:0], 32'h0, c[1] ? 3'h1 : KER_NS, {1'b0, trp[c], 32'h0});
			xf(1'b0, v[13:0], 32'h0, c[0] ? KER_S : HYP, 34'h0);
		end
		xf(1'b1, TRP, 32'h0, HYP, 34'h0);
		xf(1'b1, DOM, DSEC, KER_S, 34'h0);
		xf(1'b1, DOM, DNSEC, KER_NS, 34'h0);
		xf(1'b0, DOM, 32'h0, KER_S, {2'h0, DSEC});
		xf(1'b0, DOM, 32'h0, KER_NS, {2'h0, DNSEC});
		idle();
		for (int d = 0; d < 16; d++) dc(d[3:0], d[2] ? KER_NS : KER_S, d > 12, 1'b1);
		dc(4'h1, KER_S, 1'b0, 1'b0);
		idle();
		repeat (3) @(posedge clk);
		chk("left", 34'h0, 34'(xq.size() + dq.size()));
		summarize();
	end
endmodule : vxd_regs_tb
